// [src/lcfs_pkg.sv]
// Constants, field layout and types of the lock and fuse store
package lcfs_pkg;

    // ------------------------------------------------------------
    // Reset contents (one = unprogrammed, zero = programmed)
    // ------------------------------------------------------------
    localparam logic [7:0] LCFS_LOCK_RST = 8'hFF;
    localparam logic [7:0] LCFS_EXT_RST = 8'hFF;
    localparam logic [7:0] LCFS_HIGH_RST = 8'hDF;
    localparam logic [7:0] LCFS_LOW_RST = 8'h62;
    localparam logic [7:0] LCFS_LOCK_UNUSED = 8'hFC;
    localparam logic [7:0] LCFS_EXT_UNUSED = 8'hFE;
    localparam logic [7:0] LCFS_UNMAPPED = 8'hFF;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int LCFS_LOCK_LOW_BIT = 0;
    localparam int LCFS_LOCK_HIGH_BIT = 1;
    localparam int LCFS_SELF_PROG_BIT = 0;
    localparam int LCFS_EXT_RESET_DIS_BIT = 7;
    localparam int LCFS_DEBUG_LINK_BIT = 6;
    localparam int LCFS_SERIAL_PROG_BIT = 5;
    localparam int LCFS_WATCHDOG_BIT = 4;
    localparam int LCFS_EEPROM_PRESERVE_BIT = 3;
    localparam int LCFS_BROWNOUT_LSB = 0;
    localparam int LCFS_CLOCK_DIV8_BIT = 7;
    localparam int LCFS_CLOCK_OUT_BIT = 6;
    localparam int LCFS_STARTUP_LSB = 4;
    localparam int LCFS_CLOCK_SRC_LSB = 0;
    localparam logic [7:0] LCFS_SERIAL_PROG_MASK = 8'h20;

    // ------------------------------------------------------------
    // Selects, pointers and command bytes
    // ------------------------------------------------------------
    localparam logic [1:0] LCFS_SEL_LOW = 2'h0;
    localparam logic [1:0] LCFS_SEL_LOCK = 2'h1;
    localparam logic [1:0] LCFS_SEL_EXT = 2'h2;
    localparam logic [1:0] LCFS_SEL_HIGH = 2'h3;
    localparam logic [1:0] LCFS_SIG_ADDR_0 = 2'h0;
    localparam logic [1:0] LCFS_SIG_ADDR_1 = 2'h1;
    localparam logic [1:0] LCFS_SIG_ADDR_2 = 2'h2;
    localparam logic [15:0] LCFS_PTR_LOW = 16'h0000;
    localparam logic [15:0] LCFS_PTR_LOCK = 16'h0001;
    localparam logic [15:0] LCFS_PTR_EXT = 16'h0002;
    localparam logic [15:0] LCFS_PTR_HIGH = 16'h0003;
    localparam logic [7:0] LCFS_ERASE_BYTE1 = 8'hAC;
    localparam logic [7:0] LCFS_ERASE_BYTE2 = 8'h80;

    // ------------------------------------------------------------
    // Types
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        LCFS_OP_READ_CFG = 2'h0,
        LCFS_OP_WRITE_CFG = 2'h1,
        LCFS_OP_READ_SIG = 2'h2,
        LCFS_OP_SERIAL = 2'h3
    } lcfs_op_e;

    typedef enum logic [2:0] {
        LCFS_PM_NORMAL = 3'b001,
        LCFS_PM_SERIAL = 3'b010,
        LCFS_PM_HV = 3'b100
    } lcfs_pmode_e;

endpackage

// [src/lcfs_top.sv]
// Lock bit, fuse, signature and calibration store with access gating
// ------------------------------------------------------------
// ------------------------------------------------------------
`timescale 1ns/1ps

module lcfs_top
    import lcfs_pkg::*;
#(
    // Identity values below are arbitrary
    parameter logic [7:0] SIG_0 = 8'h5A,
    parameter logic [7:0] SIG_1 = 8'h3C,
    parameter logic [7:0] SIG_2 = 8'h66,
    parameter logic [7:0] CAL_BYTE = 8'h80
) (
    // Clock and reset
    input wire logic CLOCK_IN,
    input wire logic RESETN_IN,
    // Programming mode entry
    input wire logic PROG_SERIAL_IN,
    input wire logic PROG_HV_IN,
    // Programmer command
    input wire logic CMD_VALID_IN,
    input wire logic [1:0] CMD_OP_IN,
    input wire logic [1:0] CMD_ADDR_IN,
    input wire logic [7:0] CMD_DATA_IN,
    input wire logic [7:0] CMD_BYTE1_IN,
    input wire logic [7:0] CMD_BYTE2_IN,
    // Programmer answer
    output logic [7:0] RD_DATA_OUT,
    output logic RD_VALID_OUT,
    output logic CMD_REFUSED_OUT,
    output logic ERASE_FLASH_OUT,
    output logic ERASE_EEPROM_OUT,
    // Software read port
    input wire logic SW_RD_IN,
    input wire logic [15:0] SW_PTR_IN,
    output logic [7:0] SW_RD_DATA_OUT,
    output logic SW_RD_VALID_OUT,
    // Working fuse values and gates
    output logic [7:0] FUSE_LOW_OUT,
    output logic [7:0] FUSE_HIGH_OUT,
    output logic [7:0] FUSE_EXT_OUT,
    output logic [1:0] PROT_MODE_OUT,
    output logic PROG_ALLOW_OUT,
    output logic VERIFY_ALLOW_OUT,
    output logic DBG_READ_EN_OUT,
    output logic DBG_CTRL_EN_OUT,
    output logic EEPROM_PRESERVE_OUT,
    output logic [7:0] OSC_TRIM_OUT
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    lcfs_pmode_e pmode_q;
    lcfs_pmode_e pmode_d;
    logic [7:0] lock_q;
    logic [7:0] lock_d;
    logic [7:0] ext_q;
    logic [7:0] ext_d;
    logic [7:0] high_q;
    logic [7:0] high_d;
    logic [7:0] low_q;
    logic [7:0] low_d;
    logic [7:0] ext_w_q;
    logic [7:0] high_w_q;
    logic [7:0] low_w_q;
    logic init_q;
    logic [7:0] osc_trim_q;
    logic [7:0] rd_data_q;
    logic [7:0] rd_data_d;
    logic rd_valid_q;
    logic refused_q;
    logic erase_flash_q;
    logic erase_ee_q;
    logic [7:0] sw_data_q;
    logic [7:0] sw_data_d;
    logic sw_valid_q;

    // ------------------------------------------------------------
    // Mode and protection decode
    // ------------------------------------------------------------
    wire in_prog = pmode_q != LCFS_PM_NORMAL;
    wire in_serial = pmode_q == LCFS_PM_SERIAL;
    wire lock_low_prog = ~lock_q[LCFS_LOCK_LOW_BIT];
    wire lock_high_prog = ~lock_q[LCFS_LOCK_HIGH_BIT];
    wire prot_mode1 = !lock_low_prog && !lock_high_prog;
    // Undocumented pattern with only the upper bit programmed is treated as mode 3
    wire prot_mode3 = lock_high_prog;
    wire prot_mode2 = !prot_mode1 && !prot_mode3;
    wire fuses_open = !lock_low_prog;

    assign pmode_d = PROG_HV_IN ? LCFS_PM_HV :
                     PROG_SERIAL_IN ? LCFS_PM_SERIAL : LCFS_PM_NORMAL;

    // ------------------------------------------------------------
    // Command decode
    // ------------------------------------------------------------
    wire cmd_take = CMD_VALID_IN && in_prog;
    wire op_rd_cfg = CMD_OP_IN == LCFS_OP_READ_CFG;
    wire op_wr_cfg = CMD_OP_IN == LCFS_OP_WRITE_CFG;
    wire op_rd_sig = CMD_OP_IN == LCFS_OP_READ_SIG;
    wire op_serial = CMD_OP_IN == LCFS_OP_SERIAL;
    wire erase_bytes = CMD_BYTE1_IN == LCFS_ERASE_BYTE1 &&
                       CMD_BYTE2_IN == LCFS_ERASE_BYTE2;
    wire cmd_erase = cmd_take && op_serial && erase_bytes;
    wire cmd_wr = cmd_take && op_wr_cfg;
    wire wr_lock = cmd_wr && CMD_ADDR_IN == LCFS_SEL_LOCK;
    wire wr_fuse = cmd_wr && CMD_ADDR_IN != LCFS_SEL_LOCK;
    wire fuse_we = wr_fuse && fuses_open;
    wire cmd_rd = cmd_take && (op_rd_cfg || op_rd_sig);
    // Anything outside programming mode, a frozen fuse or a bad serial
    wire cmd_refuse = CMD_VALID_IN &&
                      (!in_prog || (wr_fuse && !fuses_open) ||
                       (op_serial && !erase_bytes));

    // ------------------------------------------------------------
    // Stored (nonvolatile) contents
    // ------------------------------------------------------------
    // Lock bits only ever go to programmed on a write
    wire [7:0] lock_wr = lock_q & (CMD_DATA_IN | LCFS_LOCK_UNUSED);
    // Serial enable keeps its value while written in serial mode
    wire [7:0] high_wr = in_serial ?
        ((CMD_DATA_IN & ~LCFS_SERIAL_PROG_MASK) |
         (high_q & LCFS_SERIAL_PROG_MASK)) : CMD_DATA_IN;

    assign lock_d = cmd_erase ? LCFS_LOCK_RST :
                    wr_lock ? lock_wr : lock_q;
    // Erase leaves all fuse bytes alone
    assign ext_d = (fuse_we && CMD_ADDR_IN == LCFS_SEL_EXT) ?
                   (CMD_DATA_IN | LCFS_EXT_UNUSED) : ext_q;
    assign high_d = (fuse_we && CMD_ADDR_IN == LCFS_SEL_HIGH) ?
                    high_wr : high_q;
    assign low_d = (fuse_we && CMD_ADDR_IN == LCFS_SEL_LOW) ?
                   CMD_DATA_IN : low_q;

    // Power-up models the factory contents of the store
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            lock_q <= LCFS_LOCK_RST;
            ext_q <= LCFS_EXT_RST;
            high_q <= LCFS_HIGH_RST;
            low_q <= LCFS_LOW_RST;
        end else begin
            lock_q <= lock_d;
            ext_q <= ext_d;
            high_q <= high_d;
            low_q <= low_d;
        end
    end

    // ------------------------------------------------------------
    // Working latches
    // ------------------------------------------------------------
    // Reload on power-up and on every mode change, so fuse writes
    // made in programming mode only act once the mode is left.
    wire load_w = !init_q || (pmode_d != pmode_q);

    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            pmode_q <= LCFS_PM_NORMAL;
            init_q <= 1'b0;
            ext_w_q <= LCFS_EXT_RST;
            high_w_q <= LCFS_HIGH_RST;
            low_w_q <= LCFS_LOW_RST;
        end else begin
            pmode_q <= pmode_d;
            init_q <= 1'b1;
            if (load_w) begin
                ext_w_q <= ext_q;
                high_w_q <= high_q;
                low_w_q <= low_q;
            end
        end
    end

    // ------------------------------------------------------------
    // Calibration
    // ------------------------------------------------------------
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            osc_trim_q <= CAL_BYTE;
        end else begin
            osc_trim_q <= osc_trim_q;
        end
    end

    // ------------------------------------------------------------
    // Read paths (raw stored encoding: programmed reads zero)
    // ------------------------------------------------------------
    wire [7:0] cfg_mux = CMD_ADDR_IN == LCFS_SEL_LOW ? low_q :
                         CMD_ADDR_IN == LCFS_SEL_LOCK ? lock_q :
                         CMD_ADDR_IN == LCFS_SEL_EXT ? ext_q :
                         high_q;
    // Signature space ignores lock state; address 3 returns calibration
    wire [7:0] sig_mux = CMD_ADDR_IN == LCFS_SIG_ADDR_0 ? SIG_0 :
                         CMD_ADDR_IN == LCFS_SIG_ADDR_1 ? SIG_1 :
                         CMD_ADDR_IN == LCFS_SIG_ADDR_2 ? SIG_2 :
                         CAL_BYTE;
    assign rd_data_d = op_rd_sig ? sig_mux : cfg_mux;

    assign sw_data_d = SW_PTR_IN == LCFS_PTR_LOW ? low_q :
                       SW_PTR_IN == LCFS_PTR_LOCK ? lock_q :
                       SW_PTR_IN == LCFS_PTR_EXT ? ext_q :
                       SW_PTR_IN == LCFS_PTR_HIGH ? high_q :
                       LCFS_UNMAPPED;

    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rd_data_q <= 8'h00;
            rd_valid_q <= 1'b0;
            refused_q <= 1'b0;
            sw_data_q <= 8'h00;
            sw_valid_q <= 1'b0;
        end else begin
            if (cmd_rd) begin
                rd_data_q <= rd_data_d;
            end
            rd_valid_q <= cmd_rd;
            refused_q <= cmd_refuse;
            if (SW_RD_IN) begin
                sw_data_q <= sw_data_d;
            end
            sw_valid_q <= SW_RD_IN;
        end
    end

    // ------------------------------------------------------------
    // Chip erase strobes
    // ------------------------------------------------------------
    // Preservation reads the stored bit, not the latch, so it acts
    // as soon as it is programmed.
    always_ff @(posedge CLOCK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            erase_flash_q <= 1'b0;
            erase_ee_q <= 1'b0;
        end else begin
            erase_flash_q <= cmd_erase;
            erase_ee_q <= cmd_erase &&
                          high_q[LCFS_EEPROM_PRESERVE_BIT];
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign RD_DATA_OUT = rd_data_q;
    assign RD_VALID_OUT = rd_valid_q;
    assign CMD_REFUSED_OUT = refused_q;
    assign ERASE_FLASH_OUT = erase_flash_q;
    assign ERASE_EEPROM_OUT = erase_ee_q;
    assign SW_RD_DATA_OUT = sw_data_q;
    assign SW_RD_VALID_OUT = sw_valid_q;
    assign FUSE_LOW_OUT = low_w_q;
    assign FUSE_HIGH_OUT = high_w_q;
    assign FUSE_EXT_OUT = ext_w_q;
    assign OSC_TRIM_OUT = osc_trim_q;
    assign PROT_MODE_OUT = prot_mode1 ? 2'h1 : prot_mode2 ? 2'h2 : 2'h3;
    assign PROG_ALLOW_OUT = in_prog && prot_mode1;
    assign VERIFY_ALLOW_OUT = in_prog && !prot_mode3;
    // Reads over the debug link bypass the lock bits entirely
    assign DBG_READ_EN_OUT = !high_w_q[LCFS_DEBUG_LINK_BIT];
    assign DBG_CTRL_EN_OUT = DBG_READ_EN_OUT && prot_mode1;
    assign EEPROM_PRESERVE_OUT =
        !high_q[LCFS_EEPROM_PRESERVE_BIT];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking @(posedge CLOCK_IN);
    endclocking
    default disable iff (!RESETN_IN);

    sequence s_enter_prog;
        pmode_q == LCFS_PM_NORMAL ##1 pmode_q != LCFS_PM_NORMAL;
    endsequence

    sequence s_erase_cmd;
        cmd_erase ##1 1'b1;
    endsequence

    a_lock_erase_only: assert property (
        $rose(lock_q[LCFS_LOCK_LOW_BIT]) |-> $past(cmd_erase))
        else $error("lock bit returned to one without erase");

    a_erase_keeps_fuses: assert property (
        s_erase_cmd |-> high_q == $past(high_q) &&
        low_q == $past(low_q) && ext_q == $past(ext_q))
        else $error("chip erase changed a fuse");

    a_fuse_freeze: assert property (
        wr_fuse && lock_low_prog |=>
        $stable(high_q) && $stable(low_q) && $stable(ext_q) &&
        CMD_REFUSED_OUT)
        else $error("fuse changed while locked");

    a_serial_enable_kept: assert property (
        in_serial && cmd_wr && CMD_ADDR_IN == LCFS_SEL_HIGH |=>
        high_q[LCFS_SERIAL_PROG_BIT] ==
        $past(high_q[LCFS_SERIAL_PROG_BIT]))
        else $error("serial enable changed in serial mode");

    a_latch_entry: assert property (
        s_enter_prog |-> high_w_q == $past(high_q) &&
        low_w_q == $past(low_q))
        else $error("fuses not latched at programming entry");

    a_latch_hold: assert property (
        in_prog && $stable(pmode_q) && $past(init_q) |->
        low_w_q == $past(low_w_q) && high_w_q == $past(high_w_q))
        else $error("working fuses moved inside programming mode");

    a_eeprom_erase: assert property (
        cmd_erase |=> ERASE_FLASH_OUT && ERASE_EEPROM_OUT ==
        $past(high_q[LCFS_EEPROM_PRESERVE_BIT]))
        else $error("wrong erase strobes");

    a_prog_gate: assert property (
        PROG_ALLOW_OUT |-> lock_q[1:0] == 2'b11 && !DBG_CTRL_EN_OUT ==
        high_w_q[LCFS_DEBUG_LINK_BIT])
        else $error("programming allowed while locked");

    a_verify_gate: assert property (
        lock_high_prog |-> !VERIFY_ALLOW_OUT && !PROG_ALLOW_OUT &&
        PROT_MODE_OUT == 2'h3)
        else $error("verify allowed in mode 3");

    a_sw_lock_read: assert property (
        SW_RD_IN && SW_PTR_IN == LCFS_PTR_LOCK |=>
        SW_RD_VALID_OUT && SW_RD_DATA_OUT == $past(lock_q))
        else $error("software lock read wrong");

    a_sig_read: assert property (
        cmd_take && op_rd_sig && CMD_ADDR_IN == LCFS_SIG_ADDR_0 |=>
        RD_VALID_OUT && RD_DATA_OUT == SIG_0)
        else $error("signature byte 0 wrong");

    a_trim_loaded: assert property (
        init_q |-> OSC_TRIM_OUT == CAL_BYTE)
        else $error("trim not loaded from calibration byte");

    a_unused_ones: assert property (
        &lock_q[7:2] && &ext_q[7:1] && &FUSE_EXT_OUT[7:1])
        else $error("unused bit read as zero");

endmodule

// [verification/lcfs_prog_model.sv]
// Programmer model: enters programming modes and issues single commands
`timescale 1ns/1ps
module lcfs_prog_model (
    // Clock
    input wire logic clk_in,
    // Mode entry and command
    output logic serial_out,
    output logic hv_out,
    output logic valid_out,
    output logic [1:0] op_out,
    output logic [1:0] addr_out,
    output logic [7:0] data_out,
    output logic [7:0] byte1_out,
    output logic [7:0] byte2_out,
    // Answer from the store
    input wire logic [7:0] rd_data_in,
    input wire logic rd_valid_in,
    input wire logic refused_in,
    input wire logic erase_flash_in,
    input wire logic erase_eeprom_in
);
    logic [7:0] rd_q = 8'h00;
    logic rd_valid_q = 1'b0;
    logic refused_q = 1'b0;
    logic flash_q = 1'b0;
    logic eeprom_q = 1'b0;
    logic no_serial_q = 1'b0;

    initial begin
        {serial_out, hv_out, valid_out} = 3'h0;
        {op_out, addr_out} = 4'h0;
        {data_out, byte1_out, byte2_out} = 24'h0;
    end

    // Mode inputs are registered once, latches reload on that same edge
    task automatic set_mode(input logic s, input logic h);
        @(negedge clk_in);
        serial_out = s & ~no_serial_q;
        hv_out = h;
        repeat (2) @(negedge clk_in);
    endtask

    // Gap adds that many idle cycles before the command is driven
    task automatic cmd(input logic [1:0] op, input logic [1:0] addr,
        input logic [7:0] data, input logic [7:0] b1, input logic [7:0] b2,
        input int gap);
        repeat (gap + 1) @(negedge clk_in);
        valid_out = 1'b1;
        {op_out, addr_out, data_out, byte1_out, byte2_out} =
            {op, addr, data, b1, b2};
        if (op == 2'h1 && addr == 2'h3 && !data[7]) no_serial_q = 1'b1;
        @(negedge clk_in);
        {rd_valid_q, refused_q} = {rd_valid_in, refused_in};
        {flash_q, eeprom_q} = {erase_flash_in, erase_eeprom_in};
        if (rd_valid_in) rd_q = rd_data_in;
        // Released lines show the inverse, not the stale value
        valid_out = 1'b0;
        {op_out, addr_out, data_out, byte1_out, byte2_out} =
            ~{op, addr, data, b1, b2};
    endtask
endmodule

// [verification/tb_lock_fuse_config_store.sv]
// Self-checking bench for the lock, fuse and signature store
`timescale 1ns/1ps
module tb_lock_fuse_config_store;
    import lcfs_pkg::*;
    typedef struct packed {
        logic [1:0] op;
        logic [1:0] addr;
        logic [7:0] data;
        logic [7:0] exp;
        logic refused;
    } lcfs_row_s;
    // Identity values are arbitrary
    localparam logic [7:0] SIG0 = 8'hA5;
    localparam logic [7:0] SIG1 = 8'h4B;
    localparam logic [7:0] SIG2 = 8'hC3;
    localparam logic [7:0] CAL = 8'h6D;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ser, hv, cv, sw_rd = 1'b0, rv, cr, ef, ee, sw_valid;
    logic prog_ok, ver_ok, dbg_rd, dbg_ctl, keep_ee;
    logic [1:0] op, addr, prot;
    logic [7:0] data, b1, b2, rd, sw_data, f_low, f_high, f_ext, trim;
    logic [15:0] sw_ptr = 16'h0000;
    int failures = 0;
    int num_checks = 0;
    lcfs_row_s rows [19];

    always #20 clk = ~clk;

    lcfs_top #(.SIG_0(SIG0), .SIG_1(SIG1), .SIG_2(SIG2), .CAL_BYTE(CAL))
    lcfs_top_inst (.CLOCK_IN(clk), .RESETN_IN(rst_n), .PROG_SERIAL_IN(ser),
        .PROG_HV_IN(hv), .CMD_VALID_IN(cv), .CMD_OP_IN(op),
        .CMD_ADDR_IN(addr), .CMD_DATA_IN(data), .CMD_BYTE1_IN(b1),
        .CMD_BYTE2_IN(b2), .RD_DATA_OUT(rd), .RD_VALID_OUT(rv),
        .CMD_REFUSED_OUT(cr), .ERASE_FLASH_OUT(ef), .ERASE_EEPROM_OUT(ee),
        .SW_RD_IN(sw_rd), .SW_PTR_IN(sw_ptr), .SW_RD_DATA_OUT(sw_data),
        .SW_RD_VALID_OUT(sw_valid), .FUSE_LOW_OUT(f_low),
        .FUSE_HIGH_OUT(f_high), .FUSE_EXT_OUT(f_ext), .PROT_MODE_OUT(prot),
        .PROG_ALLOW_OUT(prog_ok), .VERIFY_ALLOW_OUT(ver_ok),
        .DBG_READ_EN_OUT(dbg_rd), .DBG_CTRL_EN_OUT(dbg_ctl),
        .EEPROM_PRESERVE_OUT(keep_ee), .OSC_TRIM_OUT(trim));

    lcfs_prog_model lcfs_prog_model_inst (.clk_in(clk), .serial_out(ser),
        .hv_out(hv), .valid_out(cv), .op_out(op), .addr_out(addr),
        .data_out(data), .byte1_out(b1), .byte2_out(b2), .rd_data_in(rd),
        .rd_valid_in(rv), .refused_in(cr), .erase_flash_in(ef),
        .erase_eeprom_in(ee));

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [7:0] seen,
        input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d failures %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic do_reset();
        @(negedge clk);
        rst_n = 1'b0;
        repeat (12) @(negedge clk);
        rst_n = 1'b1;
    endtask

    task automatic sw_read(input logic [15:0] ptr, input logic [7:0] exp);
        @(negedge clk);
        sw_rd = 1'b1;
        sw_ptr = ptr;
        @(negedge clk);
        chk("sw valid", {7'h0, sw_valid}, 8'h01);
        chk("sw data", sw_data, exp);
        sw_rd = 1'b0;
        sw_ptr = ~ptr;
    endtask

    task automatic erase(input logic [7:0] second);
        lcfs_prog_model_inst.cmd(2'h3, 2'h0, 8'h00, 8'hAC, second, 0);
    endtask

    // ------------------------------------------------------------
    // Hang guard
    // ------------------------------------------------------------
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        $display("MISMATCH run length expected finish seen timeout");
        wrap_up();
    end

    initial begin
        // Fuses are written before the lock bits
        rows = '{'{0,0,0,8'h62,0}, '{0,1,0,8'hFF,0}, '{0,2,0,8'hFF,0},
            '{0,3,0,8'hDF,0}, '{2,0,0,SIG0,0}, '{2,1,0,SIG1,0},
            '{2,2,0,SIG2,0}, '{2,3,0,CAL,0}, '{1,3,8'hF7,0,0},
            '{0,3,0,8'hD7,0}, '{1,2,8'h00,0,0}, '{0,2,0,8'hFE,0},
            '{1,0,8'hE2,0,0}, '{0,0,0,8'hE2,0}, '{1,1,8'hFE,0,0},
            '{0,1,0,8'hFE,0}, '{1,0,8'h00,0,1}, '{0,0,0,8'hE2,0},
            '{2,0,0,SIG0,0}};
        do_reset();
        chk("low latch", f_low, 8'h62);
        chk("high latch", f_high, 8'hDF);
        chk("ext latch", f_ext, 8'hFF);
        chk("trim", trim, CAL);
        chk("mode", {6'h0, prot}, 8'h01);
        // Outside programming mode every command is turned away
        lcfs_prog_model_inst.cmd(2'h2, 2'h0, 8'h00, 8'h00, 8'h00, 0);
        chk("normal refused", {7'h0, lcfs_prog_model_inst.refused_q}, 8'h01);
        chk("normal no read", {7'h0, lcfs_prog_model_inst.rd_valid_q}, 8'h00);
        $display("test reset done");
        lcfs_prog_model_inst.set_mode(1'b1, 1'b0);
        chk("prog allow", {7'h0, prog_ok}, 8'h01);
        foreach (rows[i]) begin
            lcfs_prog_model_inst.cmd(rows[i].op, rows[i].addr, rows[i].data,
                8'h00, 8'h00, i % 3);
            chk("refused", {7'h0, lcfs_prog_model_inst.refused_q},
                {7'h0, rows[i].refused});
            chk("rd valid", {7'h0, lcfs_prog_model_inst.rd_valid_q},
                {7'h0, !rows[i].op[0]});
            if (!rows[i].op[0]) begin
                chk("read", lcfs_prog_model_inst.rd_q, rows[i].exp);
            end
        end
        $display("test table done");
        chk("mode two", {6'h0, prot}, 8'h02);
        chk("prog mode two", {7'h0, prog_ok}, 8'h00);
        chk("verify mode two", {7'h0, ver_ok}, 8'h01);
        chk("dbg ctl", {7'h0, dbg_ctl}, 8'h00);
        chk("dbg read", {7'h0, dbg_rd}, 8'h00);
        chk("high held", f_high, 8'hDF);
        chk("preserve", {7'h0, keep_ee}, 8'h01);
        sw_read(16'h0000, 8'hE2);
        sw_read(16'h0001, 8'hFE);
        sw_read(16'h0003, 8'hD7);
        sw_read(16'h0010, 8'hFF);
        lcfs_prog_model_inst.set_mode(1'b0, 1'b0);
        chk("high new", f_high, 8'hD7);
        chk("low new", f_low, 8'hE2);
        chk("ext new", f_ext, 8'hFE);
        $display("test latch done");
        lcfs_prog_model_inst.set_mode(1'b0, 1'b1);
        lcfs_prog_model_inst.cmd(2'h1, 2'h1, 8'hFC, 8'h00, 8'h00, 0);
        chk("mode three", {6'h0, prot}, 8'h03);
        chk("verify three", {7'h0, ver_ok}, 8'h00);
        lcfs_prog_model_inst.cmd(2'h1, 2'h1, 8'hFF, 8'h00, 8'h00, 0);
        lcfs_prog_model_inst.cmd(2'h0, 2'h1, 8'h00, 8'h00, 8'h00, 0);
        chk("lock kept", lcfs_prog_model_inst.rd_q, 8'hFC);
        erase(8'h53);
        chk("bad erase", {7'h0, lcfs_prog_model_inst.refused_q}, 8'h01);
        chk("no flash erase", {7'h0, lcfs_prog_model_inst.flash_q}, 8'h00);
        erase(8'h80);
        chk("flash erase", {7'h0, lcfs_prog_model_inst.flash_q}, 8'h01);
        chk("ee kept", {7'h0, lcfs_prog_model_inst.eeprom_q}, 8'h00);
        lcfs_prog_model_inst.cmd(2'h0, 2'h1, 8'h00, 8'h00, 8'h00, 1);
        chk("lock erased", lcfs_prog_model_inst.rd_q, 8'hFF);
        lcfs_prog_model_inst.cmd(2'h0, 2'h3, 8'h00, 8'h00, 8'h00, 0);
        chk("fuse survives", lcfs_prog_model_inst.rd_q, 8'hD7);
        lcfs_prog_model_inst.set_mode(1'b0, 1'b0);
        $display("test erase done");
        do_reset();
        lcfs_prog_model_inst.set_mode(1'b0, 1'b1);
        lcfs_prog_model_inst.cmd(2'h1, 2'h3, 8'hBF, 8'h00, 8'h00, 0);
        lcfs_prog_model_inst.cmd(2'h0, 2'h3, 8'h00, 8'h00, 8'h00, 0);
        chk("hv high", lcfs_prog_model_inst.rd_q, 8'hBF);
        lcfs_prog_model_inst.set_mode(1'b0, 1'b0);
        chk("dbg read on", {7'h0, dbg_rd}, 8'h01);
        chk("dbg ctl on", {7'h0, dbg_ctl}, 8'h01);
        lcfs_prog_model_inst.set_mode(1'b0, 1'b1);
        lcfs_prog_model_inst.cmd(2'h1, 2'h1, 8'hFE, 8'h00, 8'h00, 2);
        chk("dbg read locked", {7'h0, dbg_rd}, 8'h01);
        chk("dbg ctl locked", {7'h0, dbg_ctl}, 8'h00);
        erase(8'h80);
        chk("ee erased", {7'h0, lcfs_prog_model_inst.eeprom_q}, 8'h01);
        lcfs_prog_model_inst.set_mode(1'b0, 1'b0);
        $display("test debug done");
        wrap_up();
    end
endmodule
